// ### flash_host_pkg.sv
/*
 * constants and carrier types for the parallel flash host controller.
 * assumes a 125 MHz system clock; all times are converted to cycle counts here.
 */
package flash_host_pkg;
   localparam int unsigned clk_mhz = 125;
   // reset pulse: 25 us when an algorithm runs, 100 ns during reads
   localparam int unsigned reset_busy_us = 25;
   localparam int unsigned reset_read_ns = 100;
   localparam int unsigned reset_busy_cyc = reset_busy_us * clk_mhz;
   localparam int unsigned reset_read_cyc = (reset_read_ns * clk_mhz + 999) / 1000;
   // erase progress before a suspend may be issued
   localparam int unsigned erase_run_us = 500;
   localparam int unsigned erase_run_cyc = erase_run_us * clk_mhz;
   // suspend latency until readable
   localparam int unsigned susp_max_us = 20;
   localparam int unsigned susp_max_cyc = susp_max_us * clk_mhz;
   // recovery after reset before outputs are trusted (reset time, 100 ns)
   localparam int unsigned recov_ns = 100;
   localparam int unsigned recov_cyc = (recov_ns * clk_mhz + 999) / 1000;
   // bus strobe widths: write pulse 60 ns, high 30 ns, read access 75 ns
   localparam int unsigned wr_pulse_ns = 60;
   localparam int unsigned wr_pulse_cyc = (wr_pulse_ns * clk_mhz + 999) / 1000;
   localparam int unsigned wr_high_ns = 30;
   localparam int unsigned wr_high_cyc = (wr_high_ns * clk_mhz + 999) / 1000;
   localparam int unsigned rd_access_ns = 75;
   localparam int unsigned rd_access_cyc = (rd_access_ns * clk_mhz + 999) / 1000;
   localparam int unsigned cnt_w = 24;

   typedef enum logic [1:0] {
      op_read = 2'b00,
      op_write = 2'b01,
      op_reset = 2'b10,
      op_suspend = 2'b11
   } op_e;

   typedef struct packed {
      op_e op;
      logic [23:0] addr;
      logic [15:0] data;
   } req_s;

   typedef struct packed {
      logic chip_sel_a;
      logic chip_sel_b;
      logic chip_sel_c;
      logic oe_n;
      logic we_n;
      logic power_down_reset_n;
      logic byte_wide;
   } pins_s;
endpackage

// ### flash_host_ctrl.sv
/*
 * host-side controller driving an asynchronous parallel nor flash through its pins.
 * assumes the flash pins are sampled through two flip-flops; the testbench resolves
 * the data bus from o_dq_out / o_dq_oe and the flash drive.
 */
// Overview of operation
// R1 - device selected when all selects low, or select c high and a,b not both high.
// R2 - single-device systems may tie selects c and b low; a alone selects.
// R3 - selected with oe low, we high, reset high: device drives data.
// R4 - host never asserts oe and we together; reads win if both.
// R5 - bus eight bits wide with byte select low, sixteen when high.
// R6 - at lockout level reads allowed, program, erase, lock changes refused.
// R7 - ready/busy driven low while the internal sequencer runs an algorithm.
// R8 - ready/busy released when idle, suspended, or in reset power-down.
// R9 - internal sequencer runs algorithms; host uses ordinary bus cycles only.
// R10 - selected write with we low, oe high latches data as a command.
// R11 - host allows 500 us erase progress before the next erase suspend.
// R12 - after suspend request, device readable within 20 us maximum.
// R13 - full aligned buffer program done in 654, 2000 or 3600 us.
// R14 - those buffer program bounds hold only for full aligned buffers.
// R15 - clearing all lock bits takes up to 1 s, reporting busy.
// R16 - in pulse mode each ready/busy low pulse lasts typically 500 ns.
// R17 - reset held low at least 25 us during an algorithm.
// R18 - reset held low at least 100 ns during reads only.
// R19 - outputs valid only after recovery from later of reset or ready rising.
// R20 - reset low aborts algorithms, outputs and ready/busy go high-impedance.
// R21 - selected with oe high, data outputs are high-impedance.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int unsigned reset_busy_cycles = reset_busy_cyc,
   parameter int unsigned erase_run_cycles = erase_run_cyc,
   parameter int unsigned susp_max_cycles = susp_max_cyc
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_req_valid,
   input wire req_s i_req,
   input wire logic i_byte_wide,
   input wire logic i_erase_started,
   input wire logic [15:0] i_dq_in,
   input wire logic i_ready_busy,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [15:0] o_rsp_data,
   output logic o_timeout,
   output pins_s o_pins,
   output logic [23:0] o_addr,
   output logic [15:0] o_dq_out,
   output logic o_dq_oe
);
   // counts must fit the shared cycle counter, or the waits would wrap
   if (reset_busy_cycles < 1 || erase_run_cycles < 1 || susp_max_cycles < 1 ||
         reset_busy_cycles >= (1 << cnt_w) || erase_run_cycles >= (1 << cnt_w) ||
         susp_max_cycles >= (1 << cnt_w)) begin : g_bad_counts
      $error("cycle counts must lie between one and the counter range");
   end

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_read = 3'b001,
      st_write = 3'b010,
      st_gap = 3'b011,
      st_reset = 3'b100,
      st_recov = 3'b101,
      st_susp = 3'b110
   } state_e;

   state_e state;
   logic [cnt_w-1:0] cnt;
   logic [cnt_w-1:0] erase_age;
   logic erase_active;
   logic rb_meta;
   logic rb_sync;
   logic [15:0] dq_meta;
   logic [15:0] dq_sync;
   logic susp_wait;

   // -----------------------------------------
   // pin synchronisers
   // -----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rb_meta <= 1'b1;
         rb_sync <= 1'b1;
         dq_meta <= 16'h0000;
         dq_sync <= 16'h0000;
      end else begin
         rb_meta <= i_ready_busy;
         rb_sync <= rb_meta;
         dq_meta <= i_dq_in;
         dq_sync <= dq_meta;
      end
   end

   // -----------------------------------------
   // erase progress age, gating suspends
   // -----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         erase_active <= 1'b0;
         erase_age <= '0;
      end else if (i_erase_started) begin
         erase_active <= 1'b1;
         erase_age <= '0;
      end else if (state == st_reset) begin
         erase_active <= 1'b0; // [R20]
      end else if (erase_active && erase_age < cnt_w'(erase_run_cycles)) begin
         erase_age <= erase_age + 1'b1;
      end
   end

   // -----------------------------------------
   // bus sequencer
   // -----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state <= st_idle;
         cnt <= '0;
         susp_wait <= 1'b0;
         o_req_ready <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_rsp_data <= 16'h0000;
         o_timeout <= 1'b0;
         // deselected: a high, b and c low [R1] [R2]
         o_pins <= '{chip_sel_a: 1'b1, chip_sel_b: 1'b0, chip_sel_c: 1'b0,
                     oe_n: 1'b1, we_n: 1'b1, power_down_reset_n: 1'b1, byte_wide: 1'b1};
         o_addr <= 24'h000000;
         o_dq_out <= 16'h0000;
         o_dq_oe <= 1'b0;
      end else begin
         o_rsp_valid <= 1'b0;
         o_timeout <= 1'b0;
         o_pins.byte_wide <= i_byte_wide; // [R5]
         case (state)
            st_idle: begin
               o_req_ready <= 1'b1;
               if (i_req_valid && o_req_ready) begin
                  o_req_ready <= 1'b0;
                  o_addr <= i_req.addr;
                  cnt <= '0;
                  case (i_req.op)
                     op_read: begin
                        o_pins.chip_sel_a <= 1'b0; // [R1]
                        o_pins.oe_n <= 1'b0; // [R3] [R4]
                        state <= st_read;
                     end
                     op_write: begin
                        o_pins.chip_sel_a <= 1'b0;
                        o_pins.we_n <= 1'b0; // [R10] [R4]
                        o_dq_out <= i_byte_wide ? i_req.data : {8'h00, i_req.data[7:0]};
                        o_dq_oe <= 1'b1;
                        state <= st_write;
                     end
                     op_reset: begin
                        o_pins.power_down_reset_n <= 1'b0;
                        state <= st_reset;
                     end
                     default: begin
                        // suspend command write, refused with a timeout response until erase has run [R11]
                        if (!erase_active || erase_age >= cnt_w'(erase_run_cycles)) begin
                           o_pins.chip_sel_a <= 1'b0;
                           o_pins.we_n <= 1'b0;
                           o_dq_out <= i_req.data;
                           o_dq_oe <= 1'b1;
                           susp_wait <= 1'b1;
                           state <= st_write;
                        end else begin
                           o_req_ready <= 1'b0;
                           o_rsp_valid <= 1'b1;
                           o_timeout <= 1'b1;
                        end
                     end
                  endcase
               end
            end
            st_read: begin
               cnt <= cnt + 1'b1;
               if (cnt >= cnt_w'(rd_access_cyc + 2)) begin
                  // extra two cycles cover the data synchroniser
                  o_rsp_data <= o_pins.byte_wide ? dq_sync : {8'h00, dq_sync[7:0]};
                  o_rsp_valid <= 1'b1;
                  o_pins.oe_n <= 1'b1; // [R21]
                  o_pins.chip_sel_a <= 1'b1;
                  cnt <= '0;
                  state <= st_gap;
               end
            end
            st_write: begin
               cnt <= cnt + 1'b1;
               if (cnt >= cnt_w'(wr_pulse_cyc - 1)) begin
                  o_pins.we_n <= 1'b1;
                  o_pins.chip_sel_a <= 1'b1;
                  cnt <= '0;
                  state <= susp_wait ? st_susp : st_gap;
                  o_rsp_valid <= !susp_wait;
               end
            end
            st_gap: begin
               o_dq_oe <= 1'b0;
               cnt <= cnt + 1'b1;
               if (cnt >= cnt_w'(wr_high_cyc)) begin
                  state <= st_idle;
               end
            end
            st_susp: begin
               // wait for release of ready/busy, bounded by the latency limit [R12] [R8]
               o_dq_oe <= 1'b0;
               cnt <= cnt + 1'b1;
               if (rb_sync || cnt >= cnt_w'(susp_max_cycles)) begin
                  o_timeout <= !rb_sync;
                  o_rsp_valid <= 1'b1;
                  susp_wait <= 1'b0;
                  cnt <= '0;
                  state <= st_gap;
               end
            end
            st_reset: begin
               // always hold the long pulse: safe whether or not an algorithm runs
               cnt <= cnt + 1'b1;
               if (cnt >= cnt_w'(reset_busy_cycles - 1)) begin // [R17] [R18]
                  o_pins.power_down_reset_n <= 1'b1;
                  cnt <= '0;
                  state <= st_recov;
               end
            end
            st_recov: begin
               // recovery counts from the later of reset high and ready high [R19]
               if (!rb_sync) begin
                  cnt <= '0;
               end else begin
                  cnt <= cnt + 1'b1;
                  if (cnt >= cnt_w'(recov_cyc + 1)) begin
                     o_rsp_valid <= 1'b1;
                     cnt <= '0;
                     state <= st_idle;
                  end
               end
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### flash_host_ctrl_chk.sv
/* pin-level assertions for the flash host controller.
   assumes binding to flash_host_ctrl, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_chk
   import flash_host_pkg::*;
#(
   parameter int unsigned reset_busy_cycles = reset_busy_cyc
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire logic o_timeout,
   input wire pins_s o_pins,
   input wire logic o_dq_oe
);
   // ----------
   // helpers
   // ----------
   logic [23:0] low_cnt;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || o_pins.power_down_reset_n)
         low_cnt <= 24'h0;
      else
         low_cnt <= low_cnt + 24'h1;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   sequence s_rd_start;
      $fell(o_pins.oe_n);
   endsequence
   sequence s_wr_start;
      $fell(o_pins.we_n);
   endsequence
   // ----------
   // assertions
   // ----------
   a_strobe_excl: assert property (o_pins.oe_n || o_pins.we_n)
      else $error("oe and we low together");
   a_no_contend: assert property (o_dq_oe |-> o_pins.oe_n)
      else $error("host drives bus during read");
   a_sel_tied: assert property (!o_pins.chip_sel_b && !o_pins.chip_sel_c)
      else $error("selects b c not low");
   a_read_sel: assert property (!o_pins.oe_n |-> !o_pins.chip_sel_a)
      else $error("read without select");
   a_write_width: assert property (s_wr_start |-> (!o_pins.we_n && !o_pins.chip_sel_a)[*7])
      else $error("write strobe too short");
   a_read_answer: assert property (s_rd_start |-> ##[1:20] o_rsp_valid)
      else $error("read not answered");
   // one cycle of slack for where the counter starts
   a_reset_width: assert property ($rose(o_pins.power_down_reset_n) |-> low_cnt >= reset_busy_cycles - 1)
      else $error("reset pulse too short");
   a_timeout_rsp: assert property (o_timeout |-> o_rsp_valid)
      else $error("timeout without response");
   a_idle_parked: assert property (o_req_ready |-> o_pins.chip_sel_a && o_pins.oe_n && o_pins.we_n)
      else $error("idle with strobes active");
endmodule
bind flash_host_ctrl flash_host_ctrl_chk #(.reset_busy_cycles(reset_busy_cycles)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_req_ready(o_req_ready),
   .o_rsp_valid(o_rsp_valid), .o_timeout(o_timeout), .o_pins(o_pins), .o_dq_oe(o_dq_oe));
`default_nettype wire

// ### flash_model.sv
/* behavioural flash device seen from its pins.
   assumes the bench resolves the data bus and the ready/busy pull-up. */
`timescale 1ns/1ps
`default_nettype none
module flash_model
   import flash_host_pkg::*;
(
   input wire logic i_clk_sys,
   input wire pins_s i_pins,
   input wire logic [23:0] i_addr,
   input wire logic [15:0] i_dq,
   input wire logic i_program_enable_input,
   output logic [15:0] o_dq,
   output logic [1:0] o_dq_en,
   output logic o_busy_low
);
   logic [7:0] busy_cnt = 8'h0;
   logic [7:0] cmd = 8'h0;
   logic last_we = 1'b1;
   logic [15:0] wr_word = 16'h0000;
   logic [7:0] recov_left = 8'h00;
   wire sel = (!i_pins.chip_sel_a && !i_pins.chip_sel_b && !i_pins.chip_sel_c) ||
      (i_pins.chip_sel_c && !(i_pins.chip_sel_a && i_pins.chip_sel_b));
   wire up = i_pins.power_down_reset_n;
   wire rd = up && sel && !i_pins.oe_n && recov_left == 8'h00;
   wire wr = up && sel && !i_pins.we_n && i_pins.oe_n;
   wire rise = !last_we && i_pins.we_n;
   assign o_dq = i_addr[15:0] ^ 16'h3c00;
   assign o_dq_en = {rd && i_pins.byte_wide, rd};
   // level mode only; a pulse-mode part would need another suspend wait
   assign o_busy_low = up && busy_cnt != 8'h0;
   always_ff @(posedge i_clk_sys) begin
      last_we <= i_pins.we_n;
      if (wr) begin
         cmd <= i_dq[7:0];
         wr_word <= i_dq;
      end
      // outputs stay off for a recovery time once reset and ready are both high
      if (!up)
         recov_left <= 8'(recov_cyc);
      else if (recov_left != 8'h00 && busy_cnt == 8'h0)
         recov_left <= recov_left - 8'h01;
      if (!up)
         busy_cnt <= 8'h0;
      else if (rise && cmd == 8'h20 && i_program_enable_input)
         // one short scaled run stands for any program, erase or lock-clear
         busy_cnt <= 8'hc8;
      else if (rise && cmd == 8'hb0 && busy_cnt > 8'h0c)
         busy_cnt <= 8'h0c;
      else if (busy_cnt != 8'h0)
         busy_cnt <= busy_cnt - 8'h1;
   end
endmodule
`default_nettype wire

// ### parallel_flash_bus_control_bench.sv
/* self-checking bench for the flash host controller.
   assumes flash_model on the pins, reduced timing parameters. */
`timescale 1ns/1ps
`default_nettype none
module parallel_flash_bus_control_bench;
   import flash_host_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, byte_wide = 1'b1, erase_started = 1'b0;
   req_s req = '0;
   logic req_ready, rsp_valid, timeout, dq_oe, busy_low;
   logic [15:0] rsp_data, dq_out, m_dq, rd;
   wire [15:0] dq_in;
   logic pen = 1'b1;
   logic [23:0] addr;
   logic [1:0] m_en;
   pins_s pins;
   logic to;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   wire ready_busy = !busy_low;
   // undriven lines wobble each cycle so a stale value cannot pass
   wire [15:0] wob = 16'h5a5a ^ {16{clk}};
   assign dq_in[7:0] = dq_oe ? dq_out[7:0] : m_en[0] ? m_dq[7:0] : wob[7:0];
   assign dq_in[15:8] = dq_oe ? dq_out[15:8] : m_en[1] ? m_dq[15:8] : wob[15:8];
   always #4 clk = ~clk;
   flash_host_ctrl #(.reset_busy_cycles(10), .erase_run_cycles(20), .susp_max_cycles(30)) dut (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req),
      .i_byte_wide(byte_wide), .i_erase_started(erase_started), .i_dq_in(dq_in),
      .i_ready_busy(ready_busy), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
      .o_rsp_data(rsp_data), .o_timeout(timeout), .o_pins(pins), .o_addr(addr),
      .o_dq_out(dq_out), .o_dq_oe(dq_oe));
   flash_model u_model (.i_clk_sys(clk), .i_pins(pins), .i_addr(addr), .i_dq(dq_in),
      .i_program_enable_input(pen), .o_dq(m_dq), .o_dq_en(m_en), .o_busy_low(busy_low));
   // ----------
   // shared tasks
   // ----------
   task automatic conclude();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (e !== g) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic xfer(input op_e op, input logic [23:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= {op, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 500);
      req_valid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 1000);
      if (n >= 500)
         chk("handshake", 16'h1, 16'h0);
      rd = rsp_data;
      to = timeout;
   endtask
   task automatic erase_go();
      xfer(op_write, 24'h0, 16'h0020);
      @(posedge clk);
      erase_started <= 1'b1;
      @(posedge clk);
      erase_started <= 1'b0;
      repeat (3) @(posedge clk);
      chk("busy", 16'h0, {15'h0, ready_busy});
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_read();
      xfer(op_read, 24'h001234, 16'h0);
      chk("rd16", 16'h2e34, rd);
      byte_wide <= 1'b0;
      xfer(op_read, 24'h0056a7, 16'h0);
      chk("rd8", 16'h00a7, rd);
      byte_wide <= 1'b1;
      $display("t_read done");
   endtask
   task automatic t_write();
      xfer(op_write, 24'h000010, 16'h12ff);
      chk("cmd", 16'h00ff, {8'h00, u_model.cmd});
      chk("wr16", 16'h12ff, u_model.wr_word);
      byte_wide <= 1'b0;
      xfer(op_write, 24'h000011, 16'ha5c3);
      chk("cmd8", 16'h00c3, {8'h00, u_model.cmd});
      chk("wr8", 16'h00c3, u_model.wr_word);
      byte_wide <= 1'b1;
      $display("t_write done");
   endtask
   task automatic t_lockout();
      pen <= 1'b0;
      xfer(op_write, 24'h0, 16'h0020);
      repeat (3) @(posedge clk);
      chk("locked", 16'h1, {15'h0, ready_busy});
      pen <= 1'b1;
      $display("t_lockout done");
   endtask
   task automatic t_suspend();
      erase_go();
      xfer(op_suspend, 24'h0, 16'h00b0);
      chk("young", 16'h1, {15'h0, to});
      repeat (25) @(posedge clk);
      xfer(op_suspend, 24'h0, 16'h00b0);
      chk("susp_to", 16'h0, {15'h0, to});
      chk("released", 16'h1, {15'h0, ready_busy});
      xfer(op_read, 24'h000001, 16'h0);
      chk("rd_susp", 16'h3c01, rd);
      $display("t_suspend done");
   endtask
   task automatic t_reset();
      erase_go();
      xfer(op_reset, 24'h0, 16'h0);
      chk("abort", 16'h1, {15'h0, ready_busy});
      xfer(op_read, 24'h000002, 16'h0);
      chk("rd_rst", 16'h3c02, rd);
      $display("t_reset done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_read();
      t_write();
      t_lockout();
      t_suspend();
      t_reset();
      conclude();
   end
endmodule
`default_nettype wire
